// *** hdl/lpm_pkg.sv ***
package lpm_pkg;
	// clock and millisecond prescale
	localparam int CLK_PERIOD_NS = 8;
	localparam int MS_NS         = 1000000;
	localparam int MS_CYC_DEF    = MS_NS / CLK_PERIOD_NS;
	localparam int TICK_W        = 17;

	// all low-power timing is counted in milliseconds
	localparam int TW = 20;
	typedef logic [TW-1:0] lpm_ms_t;

	localparam lpm_ms_t PSM_WIN_MS      = 20'h08854; // 34900 ms: update plus 30 s window
	localparam lpm_ms_t EDRX_PAGE_MS    = 20'h00400; // 1024 ms paging activity
	localparam lpm_ms_t EDRX_CAL_MIN_MS = 20'h14000; // 81920 ms cycle needs calibration
	localparam lpm_ms_t CAL_PERIOD_MS   = 20'h927c0; // 600000 ms calibration period
	localparam lpm_ms_t CAL_FIRST_MS    = 20'h02710; // 10000 ms first calibration gap
	localparam lpm_ms_t CAL_WAKE_MS     = 20'h0000a; // 10 ms thin calibration wake
	localparam lpm_ms_t IO_RST_MS       = 20'h000c8; // 200 ms i/o reset interval
	localparam logic [1:0] CAL_STEP_LAST = 2'h3;     // 80 s spacing reached

	typedef enum logic [1:0] {
		LPM_NONE  = 2'b00,
		LPM_SLEEP = 2'b01,
		LPM_LHIB  = 2'b10,
		LPM_HIB   = 2'b11
	} lpm_mode_e;

	typedef enum logic [2:0] {
		MS_STACK_OFF = 3'b000,
		MS_DRX       = 3'b001,
		MS_EDRX      = 3'b010,
		MS_PSM       = 3'b011,
		MS_NO_SVC    = 3'b100,
		MS_CONNECTED = 3'b101
	} lpm_modem_e;

	typedef enum logic [2:0] {
		ST_ACTIVE = 3'b000,
		ST_SLEEP  = 3'b001,
		ST_LHIB   = 3'b010,
		ST_HIB    = 3'b011,
		ST_WAKE   = 3'b100
	} lpm_state_e;

	typedef struct packed {
		logic      valid;
		lpm_mode_e mode;
	} lpm_cmd_s;

	typedef struct packed {
		logic sys_clk_en;
		logic io_supply_rail;
		logic io_reset_drive;
		logic io_retain;
		logic ram_keep;
	} lpm_pwr_s;

	// which low-power mode the modem state and usb power allow
	function automatic logic mode_allowed(lpm_mode_e m, lpm_modem_e s, logic usb);
		logic ok;
		case (m)
			LPM_SLEEP: ok = (s inside {MS_STACK_OFF, MS_DRX, MS_EDRX, MS_PSM, MS_NO_SVC});
			LPM_LHIB:  ok = !usb && (s inside {MS_STACK_OFF, MS_EDRX, MS_PSM, MS_NO_SVC});
			LPM_HIB:   ok = !usb && (s inside {MS_STACK_OFF, MS_EDRX, MS_PSM});
			default:   ok = 1'b0;
		endcase
		return ok;
	endfunction : mode_allowed

	// calibration gap doubles per step: 10, 20, 40, 80 s
	function automatic lpm_ms_t cal_interval(logic [1:0] step);
		return lpm_ms_t'(CAL_FIRST_MS << step);
	endfunction : cal_interval
endpackage : lpm_pkg

// *** hdl/lpm_ms_timer.sv ***
module lpm_ms_timer
	import lpm_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              resetn,
	input  wire logic              clk_en,
	input  wire logic              tick,
	input  wire logic              load,
	input  wire lpm_pkg::lpm_ms_t  load_val,
	output logic                   busy,
	output logic                   done
);
	lpm_ms_t cnt_reg;
	logic    done_reg;

	assign busy = (cnt_reg != '0);
	assign done = done_reg;

	// load wins over counting so a restart never loses the new value
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_reg  <= '0;
			done_reg <= 1'b0;
		end else if (clk_en) begin
			done_reg <= 1'b0;
			if (load) begin
				cnt_reg <= load_val;
			end else if (tick && busy) begin
				cnt_reg  <= cnt_reg - 20'h00001;
				done_reg <= (cnt_reg == 20'h00001);
			end
		end
	end
endmodule : lpm_ms_timer

// *** hdl/lpm_sequencer.sv ***
module lpm_sequencer
	import lpm_pkg::*;
#(
	parameter int MS_CYC = lpm_pkg::MS_CYC_DEF
) (
	input  wire logic                 clk,
	input  wire logic                 resetn,
	input  wire logic                 clk_en,
	input  wire logic                 wake_request_pin,
	input  wire logic                 host_terminal_ready_line,
	input  wire logic                 usb_bus_power_sense,
	input  wire lpm_pkg::lpm_cmd_s    low_power_config_command,
	input  wire lpm_pkg::lpm_modem_e  modem_state,
	input  wire logic                 idle_req,
	input  wire logic                 data_activity,
	input  wire logic                 psm_en,
	input  wire logic                 edrx_en,
	input  wire logic                 tau_event,
	input  wire logic                 hib_ram_keep,
	input  wire lpm_pkg::lpm_ms_t     active_window_ms,
	input  wire lpm_pkg::lpm_ms_t     edrx_cycle_ms,
	output lpm_pkg::lpm_pwr_s         pwr,
	output lpm_pkg::lpm_state_e       lp_state,
	output logic                      config_discard,
	output logic                      paging_reach,
	output logic                      psm_entry
);
	import lpm_pkg::*;

	lpm_state_e        state_reg, state_next;
	lpm_mode_e         mode_reg;
	lpm_pwr_s          pwr_reg, pwr_next;
	logic [TICK_W-1:0] tick_cnt_reg;
	logic [1:0]        cal_step_reg;
	logic              discard_reg, reach_reg, psm_entry_reg;
	logic              tick, low_st, trig, go, wake_ok, hib_win, iorst_load;
	logic              aw_load, aw_busy, aw_expired;
	logic              psm_load, psm_busy, page_run, cyc_load, cyc_busy, pg_busy;
	logic              calp_load, calp_busy, gap_load, gap_busy, cwk_busy, iorst_busy, iorst_done;

	// millisecond tick; all long times count ticks to keep counters narrow
	assign tick   = (tick_cnt_reg == TICK_W'(MS_CYC - 1));
	assign low_st = (state_reg inside {ST_SLEEP, ST_LHIB, ST_HIB});

	// idle active window; held loaded until truly idle
	assign aw_load    = (state_reg != ST_ACTIVE) || !psm_en || data_activity;
	assign aw_expired = psm_en && !aw_load && !aw_busy;
	assign trig       = idle_req || aw_expired;
	assign go = (state_reg == ST_ACTIVE) && trig && mode_allowed(mode_reg, modem_state, usb_bus_power_sense);

	// only wake sources valid for the mode are looked at
	assign wake_ok = ((state_reg inside {ST_SLEEP, ST_LHIB}) && (wake_request_pin || host_terminal_ready_line))
		|| ((state_reg == ST_HIB) && wake_request_pin);

	// hibernate rail schedule: psm window, paging, thin calibration wakes
	assign psm_load  = (state_reg == ST_HIB) && psm_en && tau_event;
	assign page_run  = low_st && edrx_en && (!psm_en || psm_busy);
	assign cyc_load  = page_run && !cyc_busy;
	assign calp_load = low_st && edrx_en && tau_event && (edrx_cycle_ms >= EDRX_CAL_MIN_MS);
	assign gap_load  = calp_busy && !gap_busy && !calp_load;
	// a load counts at once, so the rail rises on the very edge that opens its window
	assign hib_win   = psm_busy || pg_busy || cwk_busy || psm_load || cyc_load || gap_load;
	assign iorst_load = ((state_reg == ST_HIB) && (state_next == ST_WAKE))
		|| ((state_reg == ST_HIB) && hib_win && !pwr_reg.io_supply_rail);

	lpm_ms_timer u_aw   (.clk, .resetn, .clk_en, .tick, .load(aw_load), .load_val(active_window_ms),
		.busy(aw_busy), .done());
	lpm_ms_timer u_psm  (.clk, .resetn, .clk_en, .tick, .load(psm_load), .load_val(PSM_WIN_MS),
		.busy(psm_busy), .done());
	lpm_ms_timer u_cyc  (.clk, .resetn, .clk_en, .tick, .load(cyc_load), .load_val(edrx_cycle_ms),
		.busy(cyc_busy), .done());
	lpm_ms_timer u_pg   (.clk, .resetn, .clk_en, .tick, .load(cyc_load), .load_val(EDRX_PAGE_MS),
		.busy(pg_busy), .done());
	lpm_ms_timer u_calp (.clk, .resetn, .clk_en, .tick, .load(calp_load), .load_val(CAL_PERIOD_MS),
		.busy(calp_busy), .done());
	lpm_ms_timer u_gap  (.clk, .resetn, .clk_en, .tick, .load(gap_load), .load_val(cal_interval(cal_step_reg)),
		.busy(gap_busy), .done());
	lpm_ms_timer u_cwk  (.clk, .resetn, .clk_en, .tick, .load(gap_load), .load_val(CAL_WAKE_MS),
		.busy(cwk_busy), .done());
	lpm_ms_timer u_rst  (.clk, .resetn, .clk_en, .tick, .load(iorst_load), .load_val(IO_RST_MS),
		.busy(iorst_busy), .done(iorst_done));

	// mode sequencing
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_ACTIVE: begin
				if (go) begin
					case (mode_reg)
						LPM_SLEEP: state_next = ST_SLEEP;
						LPM_LHIB:  state_next = ST_LHIB;
						LPM_HIB:   state_next = ST_HIB;
						default:   state_next = ST_ACTIVE;
					endcase
				end
			end
			ST_SLEEP, ST_LHIB: begin
				if (wake_ok) begin
					state_next = ST_ACTIVE;
				end
			end
			ST_HIB: begin
				if (wake_ok) begin
					state_next = ST_WAKE;
				end
			end
			ST_WAKE: begin
				if (iorst_done) begin
					state_next = ST_ACTIVE;
				end
			end
			default: state_next = ST_ACTIVE;
		endcase
	end

	// power controls follow the next state so they move with it
	assign pwr_next.sys_clk_en     = (state_next inside {ST_ACTIVE, ST_WAKE}) || ((state_next == ST_HIB) && hib_win);
	assign pwr_next.io_supply_rail = (state_next != ST_HIB) || hib_win;
	assign pwr_next.io_reset_drive = (state_next inside {ST_HIB, ST_WAKE}) && (iorst_load || iorst_busy)
		&& !(iorst_done && (state_reg == ST_WAKE));
	assign pwr_next.io_retain      = (state_next inside {ST_SLEEP, ST_LHIB});
	assign pwr_next.ram_keep       = (state_next != ST_HIB) || hib_ram_keep;

	// state, mode and output registers; clock enable freezes everything
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg     <= ST_ACTIVE;
			mode_reg      <= LPM_NONE;
			tick_cnt_reg  <= '0;
			cal_step_reg  <= 2'h0;
			pwr_reg       <= '{sys_clk_en: 1'b1, io_supply_rail: 1'b1, io_reset_drive: 1'b0,
				io_retain: 1'b0, ram_keep: 1'b1};
			discard_reg   <= 1'b0;
			reach_reg     <= 1'b1;
			psm_entry_reg <= 1'b0;
		end else if (clk_en) begin
			state_reg     <= state_next;
			tick_cnt_reg  <= tick ? '0 : tick_cnt_reg + 17'h00001;
			pwr_reg       <= pwr_next;
			discard_reg   <= (state_next == ST_ACTIVE) && (state_reg inside {ST_LHIB, ST_WAKE});
			reach_reg     <= (state_next == ST_ACTIVE) || (page_run && pg_busy);
			psm_entry_reg <= go && aw_expired;
			if (low_power_config_command.valid && (state_reg == ST_ACTIVE)) begin
				mode_reg <= low_power_config_command.mode;
			end
			if (calp_load) begin
				cal_step_reg <= 2'h0;
			end else if (gap_load && (cal_step_reg != CAL_STEP_LAST)) begin
				cal_step_reg <= cal_step_reg + 2'h1;
			end
		end
	end

	assign pwr            = pwr_reg;
	assign lp_state       = state_reg;
	assign config_discard = discard_reg;
	assign paging_reach   = reach_reg;
	assign psm_entry      = psm_entry_reg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_hib_exit;
		(state_reg == ST_WAKE) ##1 (state_reg == ST_ACTIVE);
	endsequence

	sequence s_hib_wake_req;
		(state_reg == ST_HIB) && wake_request_pin && clk_en;
	endsequence

	sleep_clk_off_a: assert property ((state_reg == ST_SLEEP) |-> !pwr_reg.sys_clk_en && pwr_reg.io_retain)
		else $error("sleep without clock stop or i/o retention");
	hib_pin_only_a: assert property ((state_reg == ST_HIB) && !wake_request_pin |=> (state_reg == ST_HIB))
		else $error("hibernate left without wake pin");
	usb_block_a: assert property ((state_reg == ST_ACTIVE) && usb_bus_power_sense |=>
		!(state_reg inside {ST_LHIB, ST_HIB}))
		else $error("deep mode entered with usb power present");
	hib_discard_a: assert property (s_hib_exit |-> config_discard)
		else $error("hibernate exit without config discard");
	wake_reset_a: assert property (s_hib_wake_req |=> (state_reg == ST_WAKE) && pwr_reg.io_reset_drive
		&& pwr_reg.io_supply_rail)
		else $error("wake without i/o reset phase");
	rail_on_a: assert property ((state_reg != ST_HIB) |-> pwr_reg.io_supply_rail)
		else $error("i/o rail off outside hibernate");
	psm_rail_a: assert property (psm_load && clk_en && (state_next == ST_HIB) |=> pwr_reg.io_supply_rail)
		else $error("psm window did not raise rail");
	entry_allowed_a: assert property ((state_reg == ST_ACTIVE) ##1 (state_reg inside {ST_SLEEP, ST_LHIB, ST_HIB})
		|-> mode_allowed($past(mode_reg), $past(modem_state), $past(usb_bus_power_sense)))
		else $error("mode entered from forbidden modem state");
	lhib_wake_a: assert property ((state_reg == ST_LHIB) && host_terminal_ready_line && clk_en
		|=> (state_reg == ST_ACTIVE) ##0 pwr_reg.sys_clk_en)
		else $error("terminal-ready wake ignored in lite hibernate");
	ram_kept_a: assert property ((state_reg != ST_HIB) |-> pwr_reg.ram_keep)
		else $error("ram dropped outside hibernate");
	discard_pulse_a: assert property (config_discard && clk_en |=> !config_discard)
		else $error("config discard held longer than one cycle");
	wake_power_a: assert property ((state_reg == ST_WAKE) |-> pwr_reg.sys_clk_en && pwr_reg.io_supply_rail)
		else $error("wake phase without clock or rail");
	psm_entry_low_a: assert property (psm_entry |-> (state_reg inside {ST_SLEEP, ST_LHIB, ST_HIB}))
		else $error("power saving entry flagged without a low-power state");
endmodule : lpm_sequencer

// *** dv/lpm_host_model.sv ***
// host side: wake lines and mode command, all moved off the falling edge
module lpm_host_model
	import lpm_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               cmd_go,
	input  wire lpm_pkg::lpm_mode_e cmd_mode,
	input  wire logic               wake_go,
	input  wire logic               dtr_go,
	output lpm_pkg::lpm_cmd_s       cmd,
	output logic                    wake_pin,
	output logic                    dtr
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] junk_reg = 2'h0;
	// mode is don't-care outside the pulse, so it keeps moving
	always @(negedge clk) begin
		junk_reg <= junk_reg + 2'h1;
	end
	// host picks the mode; the bench also sends pairings that mode_allowed refuses
	assign cmd = '{valid: cmd_go, mode: cmd_go ? cmd_mode : lpm_mode_e'(junk_reg)};
	assign wake_pin = wake_go;
	assign dtr = dtr_go;
endmodule : lpm_host_model

// *** dv/testbench.sv ***
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import lpm_pkg::*;
	typedef struct packed {
		lpm_mode_e  mode;
		lpm_modem_e ms;
		logic       usb;
		lpm_state_e st;
	} lpm_row_s;
	localparam int MSC = 4;
	logic       clk = 1'b0, resetn = 1'b0, cmd_go = 1'b0, wake_go = 1'b0, dtr_go = 1'b0;
	logic       usb = 1'b0, idle = 1'b0, data = 1'b0, psm = 1'b0, tau = 1'b0;
	logic       en = 1'b1, edrx = 1'b0, ramk = 1'b0;
	lpm_mode_e  cmd_mode = LPM_NONE;
	lpm_modem_e ms = MS_STACK_OFF;
	lpm_ms_t    aw = 20'h00064;
	lpm_cmd_s   cmd;
	lpm_pwr_s   pwr;
	lpm_state_e st;
	logic       wake_pin, dtr, disc, reach, pent;
	int         n_mismatch = 0, checked = 0, cyc = 0, n;
	lpm_row_s   rows [13] = '{
		'{LPM_SLEEP, MS_STACK_OFF, 1'b0, ST_SLEEP}, '{LPM_SLEEP, MS_DRX, 1'b1, ST_SLEEP},
		'{LPM_SLEEP, MS_NO_SVC, 1'b0, ST_SLEEP}, '{LPM_SLEEP, MS_CONNECTED, 1'b0, ST_ACTIVE},
		'{LPM_LHIB, MS_DRX, 1'b0, ST_ACTIVE}, '{LPM_LHIB, MS_NO_SVC, 1'b0, ST_LHIB},
		'{LPM_LHIB, MS_EDRX, 1'b1, ST_ACTIVE}, '{LPM_LHIB, MS_PSM, 1'b0, ST_LHIB},
		'{LPM_HIB, MS_PSM, 1'b0, ST_HIB}, '{LPM_HIB, MS_NO_SVC, 1'b0, ST_ACTIVE},
		'{LPM_HIB, MS_EDRX, 1'b1, ST_ACTIVE}, '{LPM_NONE, MS_STACK_OFF, 1'b0, ST_ACTIVE},
		'{LPM_HIB, MS_EDRX, 1'b0, ST_HIB}};

	always #4 clk = ~clk;

	// host model owns the command and wake lines; the rest come straight from the bench
	lpm_host_model u_host (.clk(clk), .cmd_go(cmd_go), .cmd_mode(cmd_mode), .wake_go(wake_go),
		.dtr_go(dtr_go), .cmd(cmd), .wake_pin(wake_pin), .dtr(dtr));
	lpm_sequencer #(.MS_CYC(MSC)) u_dut (.clk(clk), .resetn(resetn), .clk_en(en),
		.wake_request_pin(wake_pin), .host_terminal_ready_line(dtr), .usb_bus_power_sense(usb),
		.low_power_config_command(cmd), .modem_state(ms), .idle_req(idle), .data_activity(data),
		.psm_en(psm), .edrx_en(edrx), .tau_event(tau), .hib_ram_keep(ramk), .active_window_ms(aw),
		.edrx_cycle_ms(20'h01000), .pwr(pwr), .lp_state(st), .config_discard(disc),
		.paging_reach(reach), .psm_entry(pent));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic step(input int k);
		repeat (k) @(negedge clk);
	endtask : step
	task automatic send(input lpm_mode_e m);
		cmd_mode = m;
		cmd_go = 1'b1;
		step(1);
		cmd_go = 1'b0;
	endtask : send
	task automatic pulse_idle;
		idle = 1'b1;
		step(1);
		idle = 1'b0;
	endtask : pulse_idle
	task automatic wake_by(input logic pin);
		wake_go = pin;
		dtr_go = !pin;
		step(1);
		wake_go = 1'b0;
		dtr_go = 1'b0;
	endtask : wake_by
	task automatic wait_st(input lpm_state_e s, input int lim);
		n = 0;
		while (st !== s && n < lim) begin
			step(1);
			n++;
		end
	endtask : wait_st
	task automatic report_and_stop;
		$display("mismatches %0d checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : report_and_stop

	// hang guard, well above the few thousand cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			report_and_stop();
		end
	end

	initial begin
		step(8);
		resetn = 1'b1;
		step(1);
		chk(pwr, 8'h19);
		chk({st, reach}, 8'h01);
		foreach (rows[i]) begin
			ms = rows[i].ms;
			usb = rows[i].usb;
			send(rows[i].mode);
			pulse_idle();
			chk(st, rows[i].st);
			chk(reach, rows[i].st == ST_ACTIVE);
			if (rows[i].st == ST_SLEEP) chk({pwr.sys_clk_en, pwr.io_retain}, 8'h01);
			if (rows[i].st == ST_LHIB) chk({pwr.io_supply_rail, pwr.io_retain}, 8'h03);
			if (rows[i].st == ST_HIB) begin
				chk(pwr.io_supply_rail, 8'h00);
				chk(pwr.ram_keep, 8'h00);
				wake_by(1'b0);
				chk(st, ST_HIB);
				step(1);
				wake_by(1'b1);
				chk({st, pwr.sys_clk_en, pwr.io_supply_rail, pwr.io_reset_drive}, 8'h27);
				wait_st(ST_ACTIVE, 1000);
				chk(n >= 195 * MSC && n <= 201 * MSC, 8'h01);
				chk(disc, 8'h01);
			end else if (rows[i].st != ST_ACTIVE) begin
				wake_by(1'b0);
				chk({st, disc}, {3'h0, rows[i].st == ST_LHIB});
			end
		end
		// a command while asleep must not stick
		ms = MS_DRX;
		send(LPM_SLEEP);
		pulse_idle();
		send(LPM_HIB);
		wake_by(1'b0);
		pulse_idle();
		chk(st, ST_SLEEP);
		wake_by(1'b0);
		// data every 5 ms keeps a 10 ms window from running out
		ms = MS_PSM;
		aw = 20'h0000a;
		psm = 1'b1;
		repeat (6) begin
			data = 1'b1;
			step(1);
			data = 1'b0;
			step(20);
			chk(st, ST_ACTIVE);
		end
		wait_st(ST_SLEEP, 100);
		chk({pent, n >= 13 && n <= 25}, 8'h03);
		psm = 1'b0;
		wake_by(1'b0);
		// update in hibernate brings the rail up through its reset phase
		send(LPM_HIB);
		pulse_idle();
		psm = 1'b1;
		tau = 1'b1;
		step(1);
		tau = 1'b0;
		n = 0;
		while (pwr.io_supply_rail !== 1'b1 && n < 20) begin
			step(1);
			n++;
		end
		chk({pwr.io_supply_rail, pwr.io_reset_drive}, 8'h03);
		psm = 1'b0;
		wake_by(1'b1);
		wait_st(ST_ACTIVE, 2000);
		chk(st, ST_ACTIVE);
		// reset in mid-sleep, then the stored mode must be gone
		send(LPM_SLEEP);
		pulse_idle();
		resetn = 1'b0;
		step(1);
		chk({st, pwr}, 8'h19);
		resetn = 1'b1;
		step(1);
		pulse_idle();
		chk(st, ST_ACTIVE);
		// paging in hibernate from a clean start: ram kept, rail and reach follow the page window
		ramk = 1'b1;
		edrx = 1'b1;
		send(LPM_HIB);
		pulse_idle();
		chk({st, pwr.io_supply_rail, pwr.ram_keep}, 8'h0d);
		step(2);
		chk({pwr.io_supply_rail, reach, pwr.io_reset_drive}, 8'h07);
		n = 0;
		while (pwr.io_supply_rail !== 1'b0 && n < 4200) begin
			step(1);
			n++;
		end
		chk({reach, n >= 4090 && n <= 4100}, 8'h01);
		// a low clock enable holds hibernate against the wake pin
		en = 1'b0;
		wake_by(1'b1);
		chk(st, ST_HIB);
		en = 1'b1;
		step(1);
		wake_by(1'b1);
		chk(st, ST_WAKE);
		report_and_stop();
	end
endmodule : testbench
